// File: core/tbm_pkg.sv
// register map, field positions and reset values of the timer mode block
package tbm_pkg;
    localparam logic [7:0] OFS_MODE    = 8'h00;
    localparam logic [7:0] OFS_COUNT   = 8'h04;
    localparam logic [7:0] OFS_CAP0    = 8'h08;
    localparam logic [7:0] OFS_CAP1    = 8'h0c;
    localparam logic [7:0] OFS_CMP0    = 8'h10;
    localparam logic [7:0] OFS_CMP1    = 8'h14;
    localparam logic [7:0] OFS_FF      = 8'h18;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h1c;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h20;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h24;

    // mode register fields
    localparam int BIT_CT1_EN   = 7;
    localparam int BIT_ET1_EN   = 6;
    localparam int BIT_SOFT_CAP = 5;
    localparam int BIT_CAPT_HI  = 4;
    localparam int BIT_CAPT_LO  = 3;
    localparam int BIT_CLR_EN   = 2;
    localparam int BIT_CSEL_HI  = 1;
    localparam int BIT_CSEL_LO  = 0;
    localparam logic [7:0] MODE_RESET = 8'h20;

    // capture timing and clock source codes
    localparam logic [1:0] CAPT_OFF   = 2'h0;
    localparam logic [1:0] CAPT_PINS  = 2'h1;
    localparam logic [1:0] CAPT_PINA2 = 2'h2;
    localparam logic [1:0] CAPT_TMR2  = 2'h3;
    localparam logic [1:0] CSEL_EXT   = 2'h0;
    localparam logic [1:0] CSEL_T1    = 2'h1;
    localparam logic [1:0] CSEL_T4    = 2'h2;
    localparam logic [1:0] CSEL_T16   = 2'h3;

    // interrupt status bit positions
    localparam int EV_CAP0   = 0;
    localparam int EV_CAP1   = 1;
    localparam int EV_MATCH0 = 2;
    localparam int EV_MATCH1 = 3;
    localparam int EV_NUM    = 4;

    localparam int PRESCALE_DIV_DEF = 4;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// File: core/tbm_edge_det.sv
// per-bit rising and falling edge detector for synchronous inputs
module tbm_edge_det #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] sig_in,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] prev_reg;
    logic [WIDTH-1:0] prev_next;

    if (WIDTH < 1) begin : g_bad_width
        $error("tbm_edge_det: WIDTH must be at least 1");
    end

    always_comb begin
        prev_next = sig_in;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) prev_reg <= '0;
        else     prev_reg <= prev_next;
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_edge
            assign rise[i] = sig_in[i] & ~prev_reg[i];
            assign fall[i] = ~sig_in[i] & prev_reg[i];
        end
    endgenerate
endmodule // tbm_edge_det

// File: core/tbm_top.sv
// timer b mode control with capture, compare, axi4-lite registers
// Operation
// [RULE1] two enables invert flip-flop two: on capture-two load, on compare-two match
// [RULE2] writing zero to soft capture bit copies counter into capture one
// [RULE3] capture timing: off, both pins rising, pin a both, timer out both
// [RULE4] clock source field picks external clock or prescaler taps t1, t4, t16
// [RULE5] clear enable clears the counter on compare-one match, else free run
//
// The AXI4-Lite slave port and the register addresses were decided locally.
module tbm_top #(
    parameter int CNT_W        = 16,
    parameter int PRESCALE_DIV = tbm_pkg::PRESCALE_DIV_DEF
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ext_count_clk,
    input  wire logic        capture_pin_a,
    input  wire logic        capture_pin_b,
    input  wire logic        eight_bit_timer_out,
    output logic             timer_flipflop_two,
    output logic             capture_edge_irq,
    output logic             irq
);
    if (CNT_W < 2 || CNT_W > 32 || PRESCALE_DIV < 1 || PRESCALE_DIV > 256) begin : g_bad_param
        $error("tbm_top: CNT_W or PRESCALE_DIV out of range");
    end
    localparam logic [7:0] DIV_LAST = 8'(PRESCALE_DIV - 1);
    localparam int         EV_W     = tbm_pkg::EV_NUM;

    logic [7:0]        mode_reg, mode_next;
    logic [CNT_W-1:0]  cnt_reg, cnt_next, cap0_reg, cap0_next, cap1_reg, cap1_next;
    logic [CNT_W-1:0]  cmp0_reg, cmp0_next, cmp1_reg, cmp1_next;
    logic              ff_reg, ff_next, edge_irq_reg, edge_irq_next;
    logic [EV_W-1:0]   st_reg, st_next, en_reg, en_next;
    logic [7:0]        pre_reg, pre_next;
    logic [3:0]        tap_reg, tap_next;
    logic              aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [7:0]        aw_addr_reg, aw_addr_next;
    logic [31:0]       w_data_reg, w_data_next;
    logic [3:0]        w_strb_reg, w_strb_next;
    logic              bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0]       rdata_reg, rdata_next;

    logic [3:0] pin_rise, pin_fall;
    tbm_edge_det #(.WIDTH(4)) u_edges (
        .clk    (clk),
        .rst    (rst),
        .sig_in ({ext_count_clk, eight_bit_timer_out, capture_pin_b, capture_pin_a}),
        .rise   (pin_rise),
        .fall   (pin_fall)
    );
    logic             t1, t4, t16, tick, wr_fire, soft_cap, rd_hit, wr_hit;
    logic             cap0_ev, cap1_ev, match0, match1, flip;
    logic [1:0]       capt_mode, csel;
    logic [EV_W-1:0]  events, clr_mask;
    logic [31:0]      rd_mux;

    function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old,
                                                 input logic [31:0] d, input logic [3:0] be);
        logic [31:0] r;
        r = 32'(old);
        for (int b = 0; b < 4; b++) begin
            if (be[b]) r[b*8 +: 8] = d[b*8 +: 8];
        end
        return r[CNT_W-1:0];
    endfunction
    assign capt_mode = mode_reg[tbm_pkg::BIT_CAPT_HI:tbm_pkg::BIT_CAPT_LO];
    assign csel      = mode_reg[tbm_pkg::BIT_CSEL_HI:tbm_pkg::BIT_CSEL_LO];
    assign wr_fire   = aw_hold_reg & w_hold_reg & ~bvalid_reg;

    always_comb begin
        // prescaler: t4 and t16 are sub-taps of t1 so all taps stay in phase
        t1  = (pre_reg == DIV_LAST);
        t4  = t1 & (tap_reg[1:0] == 2'h3);
        t16 = t1 & (tap_reg == 4'hf);
        pre_next = t1 ? 8'h00 : pre_reg + 8'h01;
        tap_next = t1 ? tap_reg + 4'h1 : tap_reg;
        unique case (csel) // [RULE4]
            tbm_pkg::CSEL_EXT: tick = pin_rise[3];
            tbm_pkg::CSEL_T1:  tick = t1;
            tbm_pkg::CSEL_T4:  tick = t4;
            tbm_pkg::CSEL_T16: tick = t16;
        endcase
        match0 = tick & (cnt_reg == cmp0_reg);
        match1 = tick & (cnt_reg == cmp1_reg);
        // [RULE5] clear replaces the increment on a compare-one match
        if (tick) cnt_next = (match0 & mode_reg[tbm_pkg::BIT_CLR_EN]) ? '0 : cnt_reg + 1'b1;
        else      cnt_next = cnt_reg;
        unique case (capt_mode) // [RULE3]
            tbm_pkg::CAPT_OFF:   begin cap0_ev = 1'b0;        cap1_ev = 1'b0;        end
            tbm_pkg::CAPT_PINS:  begin cap0_ev = pin_rise[0]; cap1_ev = pin_rise[1]; end
            tbm_pkg::CAPT_PINA2: begin cap0_ev = pin_rise[0]; cap1_ev = pin_fall[0]; end
            tbm_pkg::CAPT_TMR2:  begin cap0_ev = pin_rise[2]; cap1_ev = pin_fall[2]; end
        endcase
        edge_irq_next = (capt_mode == tbm_pkg::CAPT_TMR2) ? pin_rise[2] :
                        (capt_mode != tbm_pkg::CAPT_OFF) & pin_rise[0];
        soft_cap  = wr_fire & (aw_addr_reg == tbm_pkg::OFS_MODE) & w_strb_reg[0]
                  & ~w_data_reg[tbm_pkg::BIT_SOFT_CAP]; // [RULE2]
        cap0_next = (cap0_ev | soft_cap) ? cnt_reg : cap0_reg; // [RULE2]
        cap1_next = cap1_ev ? cnt_reg : cap1_reg;
        flip = (mode_reg[tbm_pkg::BIT_CT1_EN] & cap1_ev)
             | (mode_reg[tbm_pkg::BIT_ET1_EN] & match1); // [RULE1]
        ff_next = ff_reg ^ flip; // [RULE1]
        events = '0;
        events[tbm_pkg::EV_CAP0]   = cap0_ev | soft_cap;
        events[tbm_pkg::EV_CAP1]   = cap1_ev;
        events[tbm_pkg::EV_MATCH0] = match0;
        events[tbm_pkg::EV_MATCH1] = match1;
    end

    always_comb begin
        mode_next = mode_reg;
        cmp0_next = cmp0_reg;
        cmp1_next = cmp1_reg;
        en_next   = en_reg;
        clr_mask  = '0;
        wr_hit    = 1'b1;
        if (wr_fire) begin
            unique case (aw_addr_reg)
                tbm_pkg::OFS_MODE: begin
                    // soft capture bit is a strobe, always reads back as one
                    if (w_strb_reg[0]) mode_next = w_data_reg[7:0] | tbm_pkg::MODE_RESET;
                end
                tbm_pkg::OFS_CMP0:    cmp0_next = merge16(cmp0_reg, w_data_reg, w_strb_reg);
                tbm_pkg::OFS_CMP1:    cmp1_next = merge16(cmp1_reg, w_data_reg, w_strb_reg);
                tbm_pkg::OFS_IRQ_CLR: if (w_strb_reg[0]) clr_mask = w_data_reg[EV_W-1:0];
                tbm_pkg::OFS_IRQ_EN:  if (w_strb_reg[0]) en_next = w_data_reg[EV_W-1:0];
                tbm_pkg::OFS_COUNT, tbm_pkg::OFS_CAP0, tbm_pkg::OFS_CAP1,
                tbm_pkg::OFS_FF, tbm_pkg::OFS_IRQ_ST: ;
                default: wr_hit = 1'b0;
            endcase
        end
        // set wins over a clear in the same cycle
        st_next = (st_reg & ~clr_mask) | events;
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h00000000;
        unique case (s_axi_araddr)
            tbm_pkg::OFS_MODE:    rd_mux = {24'h000000, mode_reg};
            tbm_pkg::OFS_COUNT:   rd_mux = 32'(cnt_reg);
            tbm_pkg::OFS_CAP0:    rd_mux = 32'(cap0_reg);
            tbm_pkg::OFS_CAP1:    rd_mux = 32'(cap1_reg);
            tbm_pkg::OFS_CMP0:    rd_mux = 32'(cmp0_reg);
            tbm_pkg::OFS_CMP1:    rd_mux = 32'(cmp1_reg);
            tbm_pkg::OFS_FF:      rd_mux = {31'h00000000, ff_reg};
            tbm_pkg::OFS_IRQ_ST:  rd_mux = 32'(st_reg);
            tbm_pkg::OFS_IRQ_EN:  rd_mux = 32'(en_reg);
            tbm_pkg::OFS_IRQ_CLR: rd_mux = 32'h00000000;
            default:              rd_hit = 1'b0;
        endcase
    end

    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next  = w_hold_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg & ~s_axi_bready;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg & ~s_axi_rready;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        if (s_axi_awvalid & s_axi_awready) begin
            aw_hold_next = 1'b1;
            aw_addr_next = {s_axi_awaddr[7:2], 2'h0};
        end
        if (s_axi_wvalid & s_axi_wready) begin
            w_hold_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = wr_hit ? tbm_pkg::RESP_OKAY : tbm_pkg::RESP_DECERR;
        end
        if (s_axi_arvalid & s_axi_arready) begin
            rvalid_next = 1'b1;
            rdata_next  = rd_mux;
            rresp_next  = rd_hit ? tbm_pkg::RESP_OKAY : tbm_pkg::RESP_DECERR;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg <= tbm_pkg::MODE_RESET;
            cnt_reg  <= '0;
            cap0_reg <= '0;
            cap1_reg <= '0;
            cmp0_reg <= '0;
            cmp1_reg <= '0;
            ff_reg   <= 1'b0;
            st_reg   <= '0;
            en_reg   <= '0;
            pre_reg  <= 8'h00;
            tap_reg  <= 4'h0;
            edge_irq_reg <= 1'b0;
            aw_hold_reg  <= 1'b0;
            aw_addr_reg  <= 8'h00;
            w_hold_reg   <= 1'b0;
            w_data_reg   <= 32'h00000000;
            w_strb_reg   <= 4'h0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= 2'h0;
            rvalid_reg   <= 1'b0;
            rresp_reg    <= 2'h0;
            rdata_reg    <= 32'h00000000;
        end else begin
            mode_reg <= mode_next;
            cnt_reg  <= cnt_next;
            cap0_reg <= cap0_next;
            cap1_reg <= cap1_next;
            cmp0_reg <= cmp0_next;
            cmp1_reg <= cmp1_next;
            ff_reg   <= ff_next;
            st_reg   <= st_next;
            en_reg   <= en_next;
            pre_reg  <= pre_next;
            tap_reg  <= tap_next;
            edge_irq_reg <= edge_irq_next;
            aw_hold_reg  <= aw_hold_next;
            aw_addr_reg  <= aw_addr_next;
            w_hold_reg   <= w_hold_next;
            w_data_reg   <= w_data_next;
            w_strb_reg   <= w_strb_next;
            bvalid_reg   <= bvalid_next;
            bresp_reg    <= bresp_next;
            rvalid_reg   <= rvalid_next;
            rresp_reg    <= rresp_next;
            rdata_reg    <= rdata_next;
        end
    end

    assign s_axi_awready      = ~aw_hold_reg;
    assign s_axi_wready       = ~w_hold_reg;
    assign s_axi_bvalid       = bvalid_reg;
    assign s_axi_bresp        = bresp_reg;
    assign s_axi_arready      = ~rvalid_reg;
    assign s_axi_rvalid       = rvalid_reg;
    assign s_axi_rresp        = rresp_reg;
    assign s_axi_rdata        = rdata_reg;
    assign timer_flipflop_two = ff_reg;
    assign capture_edge_irq   = edge_irq_reg;
    assign irq                = |(st_reg & en_reg);

    sequence s_cap1_flip;
        mode_reg[tbm_pkg::BIT_CT1_EN] && cap1_ev && !match1;
    endsequence
    a_ff_capture_flip: assert property (@(posedge clk) disable iff (rst) // [RULE1]
        s_cap1_flip |=> timer_flipflop_two != $past(timer_flipflop_two))
        else $error("flip-flop two did not invert on capture two");
    a_ff_hold_off: assert property (@(posedge clk) disable iff (rst) // [RULE1]
        (!mode_reg[tbm_pkg::BIT_CT1_EN] && !mode_reg[tbm_pkg::BIT_ET1_EN])
        |=> $stable(timer_flipflop_two))
        else $error("flip-flop two changed with both enables off");
    a_soft_capture: assert property (@(posedge clk) disable iff (rst) // [RULE2]
        soft_cap |=> cap0_reg == $past(cnt_reg))
        else $error("soft capture did not load the counter");
    a_capture_off: assert property (@(posedge clk) disable iff (rst) // [RULE3]
        (capt_mode == tbm_pkg::CAPT_OFF && !soft_cap) |=> $stable(cap0_reg) && $stable(cap1_reg))
        else $error("capture happened while disabled");
    a_pin_b_capture: assert property (@(posedge clk) disable iff (rst) // [RULE3]
        (capt_mode == tbm_pkg::CAPT_PINS && pin_rise[1]) |=> cap1_reg == $past(cnt_reg))
        else $error("pin b rising edge not captured");
    a_count_t16: assert property (@(posedge clk) disable iff (rst) // [RULE4]
        (csel == tbm_pkg::CSEL_T16 && !t16) |=> $stable(cnt_reg))
        else $error("counter moved without its selected tap");
    a_clear_match: assert property (@(posedge clk) disable iff (rst) // [RULE5]
        (match0 && mode_reg[tbm_pkg::BIT_CLR_EN]) |=> cnt_reg == '0)
        else $error("counter not cleared on compare-one match");
    a_free_run: assert property (@(posedge clk) disable iff (rst) // [RULE5]
        (tick && !mode_reg[tbm_pkg::BIT_CLR_EN]) |=> cnt_reg == $past(cnt_reg) + 1'b1)
        else $error("counter did not increment while free running");
endmodule // tbm_top

// File: dv/tbm_far_model.sv
// far side model: external count clock, capture pins, eight bit timer output
module tbm_far_model (
    input  wire logic clk,
    output logic      ext_count_clk,
    output logic      capture_pin_a,
    output logic      capture_pin_b,
    output logic      eight_bit_timer_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ext_count_clk       = 1'b0;
        capture_pin_a       = 1'b0;
        capture_pin_b       = 1'b0;
        eight_bit_timer_out = 1'b0;
    end

    // pins move right after an edge and settle for several cycles
    task automatic set_pins(input logic a, input logic b, input logic t);
        @(posedge clk);
        capture_pin_a       <= a;
        capture_pin_b       <= b;
        eight_bit_timer_out <= t;
        repeat (4) @(posedge clk);
    endtask

    // one slow external count pulse, low again well before the next
    task automatic ext_tick();
        @(posedge clk);
        ext_count_clk <= 1'b1;
        repeat (2) @(posedge clk);
        ext_count_clk <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule // tbm_far_model

// File: dv/tb_top.sv
// self-checking bench for the timer mode block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic        ext_count_clk, capture_pin_a, capture_pin_b, eight_bit_timer_out;
    logic        timer_flipflop_two, capture_edge_irq, irq;
    int          error_cnt, num_checks;
    logic [31:0] rd;
    logic [1:0]  rsp;
    int          irq_pulses;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // capture interrupt stands one cycle, so count it edge by edge
    always @(posedge clk) begin
        if (capture_edge_irq === 1'b1) irq_pulses <= irq_pulses + 1;
    end

    // prescaler of one keeps the tap windows short
    tbm_top #(.CNT_W(16), .PRESCALE_DIV(1)) dut (.*);
    tbm_far_model far (.clk(clk), .ext_count_clk(ext_count_clk),
        .capture_pin_a(capture_pin_a), .capture_pin_b(capture_pin_b),
        .eight_bit_timer_out(eight_bit_timer_out));

    task automatic final_report();
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
        num_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic timeout();
        error_cnt++;
        final_report();
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                rsp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 64) timeout();
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                rsp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 64) timeout();
    endtask

    // soft capture on written zero only, reset value of the mode register
    task automatic t_soft();
        do_reset();
        axi_rd(tbm_pkg::OFS_MODE, rd); chk(rd, 32'h20);
        repeat (3) far.ext_tick();
        axi_wr(tbm_pkg::OFS_MODE, 32'h00);
        chk(rsp, tbm_pkg::RESP_OKAY);
        axi_rd(tbm_pkg::OFS_CAP0, rd); chk(rd, 32'h3);
        axi_rd(tbm_pkg::OFS_MODE, rd); chk(rd, 32'h20);
        repeat (2) far.ext_tick();
        axi_wr(tbm_pkg::OFS_MODE, 32'h20);
        axi_rd(tbm_pkg::OFS_CAP0, rd); chk(rd, 32'h3);
        axi_wr(tbm_pkg::OFS_IRQ_EN, 32'h1);
        @(posedge clk); chk(irq, 1'b1);
        axi_wr(tbm_pkg::OFS_IRQ_EN, 32'h0);
        @(posedge clk); chk(irq, 1'b0);
        axi_wr(tbm_pkg::OFS_IRQ_EN, 32'h1);
        // first tick at count zero also hit both zero compares, clear those too
        axi_wr(tbm_pkg::OFS_IRQ_CLR, 32'hf);
        @(posedge clk); chk(irq, 1'b0);
        axi_rd(tbm_pkg::OFS_IRQ_ST, rd); chk(rd, 32'h0);
        axi_rd(8'h80, rd); chk(rd, 32'h0);
        chk(rsp, tbm_pkg::RESP_DECERR);
    endtask

    // every capture timing code, with the capture-two toggle enabled
    task automatic t_capt();
        logic [31:0] e0, e1;
        int          p0;
        for (int m = 0; m < 4; m++) begin
            do_reset();
            axi_wr(tbm_pkg::OFS_MODE, 32'ha0 | (m << 3));
            p0 = irq_pulses;
            far.ext_tick(); far.set_pins(1'b1, 1'b0, 1'b0);
            far.ext_tick(); far.set_pins(1'b1, 1'b1, 1'b0);
            far.ext_tick(); far.set_pins(1'b0, 1'b1, 1'b0);
            far.ext_tick(); far.set_pins(1'b0, 1'b1, 1'b1);
            far.ext_tick(); far.set_pins(1'b0, 1'b1, 1'b0);
            far.set_pins(1'b0, 1'b0, 1'b0);
            e0 = (m == 3) ? 32'h4 : 32'h1;
            e1 = (m == 1) ? 32'h2 : (m == 2) ? 32'h3 : 32'h5;
            if (m == 0) begin
                axi_rd(tbm_pkg::OFS_IRQ_ST, rd); chk(rd & 32'h3, 32'h0);
            end else begin
                axi_rd(tbm_pkg::OFS_CAP0, rd); chk(rd, e0);
                axi_rd(tbm_pkg::OFS_CAP1, rd); chk(rd, e1);
            end
            chk(timer_flipflop_two, m != 0);
            chk(irq_pulses - p0, (m == 0) ? 0 : 1);
        end
    endtask

    // toggle on compare-two match, then clear on compare-one match
    task automatic t_match();
        do_reset();
        axi_wr(tbm_pkg::OFS_CMP1, 32'h2);
        axi_wr(tbm_pkg::OFS_MODE, 32'h60);
        repeat (4) far.ext_tick();
        chk(timer_flipflop_two, 1'b1);
        axi_rd(tbm_pkg::OFS_FF, rd); chk(rd, 32'h1);
        axi_rd(tbm_pkg::OFS_COUNT, rd); chk(rd, 32'h4);
        do_reset();
        axi_wr(tbm_pkg::OFS_CMP0, 32'h3);
        axi_wr(tbm_pkg::OFS_MODE, 32'h24);
        repeat (5) far.ext_tick();
        axi_rd(tbm_pkg::OFS_COUNT, rd); chk(rd, 32'h1);
    endtask

    // tap rates over a fixed window; bus latency only adds a few ticks
    task automatic t_taps();
        int div;
        for (int s = 1; s < 4; s++) begin
            div = (s == 1) ? 1 : (s == 2) ? 4 : 16;
            do_reset();
            axi_wr(tbm_pkg::OFS_MODE, 32'h20 | s);
            repeat (320) @(posedge clk);
            axi_wr(tbm_pkg::OFS_MODE, 32'h20);
            axi_rd(tbm_pkg::OFS_COUNT, rd); chk_rng(rd, 320 / div, 320 / div + 8 / div + 1);
        end
    endtask

    initial begin
        rst = 1'b1;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        error_cnt = 0;
        num_checks = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_soft();
        t_capt();
        t_match();
        t_taps();
        final_report();
    end
endmodule // tb_top
